// file: hdl/ppl_pkg.sv
package ppl_pkg;

  // Printed byte-register indices; byte address on APB is four times the index
  localparam logic [15:0] VOLT_REF_IDX = 16'h40e8;
  localparam logic [15:0] VOLT_OUT_IDX = 16'h40ea;
  localparam logic [15:0] VOLT_PROP_GAIN_IDX = 16'h40ec;
  localparam logic [15:0] VOLT_INTEG_GAIN_IDX = 16'h40ee;
  localparam logic [15:0] VOLT_OUT_UPPER_LIMIT_IDX = 16'h40f0;
  localparam logic [15:0] VOLT_OUT_LOWER_LIMIT_IDX = 16'h40f2;
  localparam logic [15:0] GAIN_MULTIPLIER_COEFF_IDX = 16'h40f3;
  localparam logic [15:0] CURRENT_REF_IDX = 16'h40f4;
  localparam logic [15:0] CURRENT_OUT_IDX = 16'h40f6;
  localparam logic [15:0] CURRENT_PROP_GAIN_IDX = 16'h40f8;
  localparam logic [15:0] CURRENT_INTEG_GAIN_IDX = 16'h40fa;
  localparam logic [15:0] CURRENT_OUT_UPPER_LIMIT_IDX = 16'h40fc;
  localparam logic [15:0] CURRENT_OUT_LOWER_LIMIT_IDX = 16'h40fe;
  localparam logic [15:0] CORRECTION_CONTROL_0_IDX = 16'h4100;

  // Word slots of the parameter store, in address order from VOLT_REF_IDX
  localparam int NUM_WORDS = 12;
  localparam int W_VREF = 0;
  localparam int W_VOUT = 1;
  localparam int W_VKP = 2;
  localparam int W_VKI = 3;
  localparam int W_VMAX = 4;
  localparam int W_VMIN = 5;
  localparam int W_IREF = 6;
  localparam int W_IOUT = 7;
  localparam int W_IKP = 8;
  localparam int W_IKI = 9;
  localparam int W_IMAX = 10;
  localparam int W_IMIN = 11;

  // Reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] CTRL0_RESET = 2'h0;

  // Fields of correction_control_0
  localparam int CTRL0_ENABLE_BIT = 0;
  localparam int CTRL0_RUN_BIT = 1;

  // Fixed-point formats of the gains
  localparam int PROP_GAIN_Q = 10;
  localparam int INTEG_GAIN_Q = 15;

  // Loop rates: inner period in ns at 250 MHz, outer loop as inner-tick ratio
  localparam int CLK_PERIOD_NS = 4;
  localparam int INNER_PERIOD_NS = 12500;
  localparam int INNER_PERIOD_CYC = INNER_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OUTER_RATIO = 200;

endpackage

// file: hdl/ppl_tick_div.sv
`timescale 1ns/10ps
module ppl_tick_div #(
  parameter int DIV = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic step,
  output logic tick
);

  localparam int CW = $clog2(DIV + 1);

  logic [CW-1:0] count;
  wire last = (count == CW'(DIV - 1));

  // Count steps while running; a stop restarts the period from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (step) begin
      count <= last ? '0 : count + CW'(1);
    end
  end

  assign tick = run && step && last;

endmodule // ppl_tick_div

// file: hdl/ppl_pi_step.sv
`timescale 1ns/10ps
module ppl_pi_step
  import ppl_pkg::*;
(
  input wire logic signed [15:0] err,
  input wire logic signed [15:0] err_prev,
  input wire logic [15:0] prop_gain,
  input wire logic [15:0] integ_gain,
  input wire logic signed [15:0] out_prev,
  input wire logic signed [15:0] out_max,
  input wire logic signed [15:0] out_min,
  output logic signed [15:0] next_out
);

  // Incremental form keeps no wide accumulator: out += kp*(e - e_prev) + ki*e
  wire signed [16:0] err_delta = 17'(err) - 17'(err_prev);
  wire signed [33:0] prop_term = ($signed({1'b0, prop_gain}) * err_delta) >>> PROP_GAIN_Q;
  wire signed [33:0] integ_term = ($signed({1'b0, integ_gain}) * err) >>> INTEG_GAIN_Q;
  wire signed [33:0] raw_sum = 34'(out_prev) + prop_term + integ_term;

  // Clamp; lower limit checked first, so a crossed pair gives the minimum below it and the maximum otherwise
  always_comb begin
    if (raw_sum < 34'(out_min)) begin
      next_out = out_min;
    end else if (raw_sum > 34'(out_max)) begin
      next_out = out_max;
    end else begin
      next_out = raw_sum[15:0];
    end
  end

endmodule // ppl_pi_step

// file: hdl/ppl_loop_regs.sv
// Functional notes
// - Voltage-loop upper output limit is 16-bit signed, reset to zero.
// - Unit disabled: voltage-loop lower-limit word is the voltage controller minimum.
// - Unit enabled: that word holds control-1 and multiplier byte, cleared to zero.
// - Multiplier byte bits 7..0, unsigned, effective only while unit enabled.
// - Unit enabled: current reference register is the current-loop set point.
// - Unit disabled: current reference register is the current-loop error input.
// - Current-loop output is signed 16-bit, software read/write, reset zero.
// - Current-loop proportional gain is Q10, MSB always zero.
// - Current-loop integral gain is Q15, MSB always zero.
// - Current-loop upper output limit is 16-bit signed, reset to zero.
// - Voltage reference is set point when enabled, error input when disabled.
// - Voltage-loop proportional gain is Q10, MSB always zero.
// - Voltage-loop integral gain is Q15, MSB always zero.
// - Unit disabled: current-loop lower-limit word is the current controller minimum.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
module ppl_loop_regs
  import ppl_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int INNER_DIV = INNER_PERIOD_CYC,
  parameter int OUTER_DIV = OUTER_RATIO
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] bus_voltage,
  input wire logic signed [15:0] input_current,
  output logic correction_unit_enable,
  output logic [7:0] correction_control_1,
  output logic [7:0] gain_multiplier_coeff,
  output logic signed [15:0] volt_loop_out,
  output logic signed [15:0] current_loop_out
);

  // Parameter store, one 16-bit word per slot
  logic [15:0] word [NUM_WORDS];
  logic [15:0] next_word [NUM_WORDS];
  logic [1:0] ctrl0;
  logic enable_d;
  logic signed [15:0] v_err_prev;
  logic signed [15:0] i_err_prev;

  // Address decode: word address is the printed byte-register index
  wire [ADDR_W-3:0] reg_idx = paddr[ADDR_W-1:2];
  wire [ADDR_W-3:0] word_offs = reg_idx - (ADDR_W-2)'(VOLT_REF_IDX);
  wire aligned = (paddr[1:0] == 2'h0);
  wire store_hit = aligned && (reg_idx >= (ADDR_W-2)'(VOLT_REF_IDX))
    && (word_offs < (ADDR_W-2)'(2 * NUM_WORDS));
  wire ctrl_hit = aligned && (reg_idx == (ADDR_W-2)'(CORRECTION_CONTROL_0_IDX));
  wire addr_hit = store_hit || ctrl_hit;
  wire [3:0] sel_word = word_offs[4:1];
  wire sel_low_byte = word_offs[0];
  wire setup_phase = psel && !penable;
  wire access_phase = psel && penable;
  wire wr_en = access_phase && pwrite && addr_hit;

  // Zero wait states; unmapped or misaligned addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_hit;

  // Mode and loop pacing
  wire unit_en = ctrl0[CTRL0_ENABLE_BIT];
  wire loops_run = ctrl0[CTRL0_RUN_BIT];
  wire enable_rise = unit_en && !enable_d;
  logic inner_tick;
  logic outer_tick;

  ppl_tick_div #(
    .DIV(INNER_DIV)
  ) u_inner_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(loops_run),
    .step(1'b1),
    .tick(inner_tick)
  );

  ppl_tick_div #(
    .DIV(OUTER_DIV)
  ) u_outer_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(loops_run),
    .step(inner_tick),
    .tick(outer_tick)
  );

  // Saturate a 17-bit difference back into 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [16:0] val);
    if (val > 17'sh07fff) begin
      return 16'sh7fff;
    end else if (val < -17'sh08000) begin
      return -16'sh8000;
    end else begin
      return val[15:0];
    end
  endfunction

  wire signed [15:0] v_err = unit_en
    ? sat16(17'($signed(word[W_VREF])) - 17'(bus_voltage))
    : $signed(word[W_VREF]);
  wire signed [15:0] i_err = unit_en
    ? sat16(17'($signed(word[W_IREF])) - 17'(input_current))
    : $signed(word[W_IREF]);

  wire signed [15:0] v_min = unit_en ? 16'sh0000 : $signed(word[W_VMIN]);
  wire signed [15:0] i_min = unit_en ? 16'sh0000 : $signed(word[W_IMIN]);

  logic signed [15:0] v_next;
  logic signed [15:0] i_next;

  ppl_pi_step u_volt_pi (
    .err(v_err),
    .err_prev(v_err_prev),
    .prop_gain(word[W_VKP]),
    .integ_gain(word[W_VKI]),
    .out_prev($signed(word[W_VOUT])),
    .out_max($signed(word[W_VMAX])),
    .out_min(v_min),
    .next_out(v_next)
  );

  ppl_pi_step u_current_pi (
    .err(i_err),
    .err_prev(i_err_prev),
    .prop_gain(word[W_IKP]),
    .integ_gain(word[W_IKI]),
    .out_prev($signed(word[W_IOUT])),
    .out_max($signed(word[W_IMAX])),
    .out_min(i_min),
    .next_out(i_next)
  );

  // Per-word byte writes; a software write beats a same-cycle hardware update
  for (genvar n = 0; n < NUM_WORDS; n++) begin : g_word
    localparam logic [7:0] HI_MASK =
      (n == W_VKP || n == W_VKI || n == W_IKP || n == W_IKI) ? 8'h7f : 8'hff;
    wire hit_n = wr_en && store_hit && (sel_word == 4'(n));
    wire hw_load = (n == W_VOUT) ? outer_tick : ((n == W_IOUT) ? inner_tick : 1'b0);
    wire [15:0] hw_val = (n == W_VOUT) ? v_next : i_next;
    wire clr = (n == W_VMIN) && enable_rise;

    always_comb begin
      next_word[n] = word[n];
      if (hit_n && sel_low_byte) begin
        next_word[n] = {word[n][15:8], pwdata[7:0]};
      end else if (hit_n) begin
        next_word[n] = {pwdata[7:0] & HI_MASK, word[n][7:0]};
      end else if (clr) begin
        next_word[n] = WORD_RESET;
      end else if (hw_load) begin
        next_word[n] = hw_val;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word[n] <= WORD_RESET;
      end else begin
        word[n] <= next_word[n];
      end
    end
  end

  // Control word and enable edge tracker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= CTRL0_RESET;
      enable_d <= 1'b0;
    end else begin
      enable_d <= unit_en;
      if (wr_en && ctrl_hit) begin
        ctrl0 <= pwdata[1:0];
      end
    end
  end

  // Previous errors for the incremental form, taken on each loop's own tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_err_prev <= 16'sh0000;
      i_err_prev <= 16'sh0000;
    end else begin
      if (outer_tick) begin
        v_err_prev <= v_err;
      end
      if (inner_tick) begin
        i_err_prev <= i_err;
      end
    end
  end

  // Read mux; the shared limit word reads back whichever meaning it holds
  wire [15:0] rd_word = word[sel_word];
  wire [7:0] rd_byte = sel_low_byte ? rd_word[7:0] : rd_word[15:8];
  wire [31:0] rd_value = ctrl_hit ? {30'h0, ctrl0} : (store_hit ? {24'h0, rd_byte} : 32'h0);

  // Read data captured in the setup cycle, stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_phase && !pwrite) begin
      prdata <= rd_value;
    end
  end

  // Shared word is only shown once the enable-rise clear has landed, so stale limit bytes never leak
  wire shared_valid = unit_en && enable_d;
  assign gain_multiplier_coeff = shared_valid ? word[W_VMIN][7:0] : 8'h00;
  assign correction_control_1 = shared_valid ? word[W_VMIN][15:8] : 8'h00;
  assign correction_unit_enable = unit_en;
  assign volt_loop_out = $signed(word[W_VOUT]);
  assign current_loop_out = $signed(word[W_IOUT]);

endmodule // ppl_loop_regs

// file: testbench/ppl_loop_regs_monitor.sv
`timescale 1ns/10ps
module ppl_loop_regs_monitor #(
  parameter int ADDR_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic correction_unit_enable,
  input wire logic [7:0] correction_control_1,
  input wire logic [7:0] gain_multiplier_coeff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of the bus, shared by the bus checks
  wire access_phase = psel && penable;
  a_ready_in_access: assert property (access_phase |-> pready) else $error("no ready in access");
  a_error_only_access: assert property (pslverr |-> access_phase) else $error("error outside access");
  a_misaligned_refused: assert property (access_phase && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access accepted");
  a_refused_reads_zero: assert property (access_phase && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_gated_multiplier: assert property (!correction_unit_enable |-> gain_multiplier_coeff == 8'h00)
    else $error("multiplier seen while disabled");
  a_gated_control: assert property (!correction_unit_enable |-> correction_control_1 == 8'h00)
    else $error("control byte seen while disabled");
  // Hazard: stale lower-limit bytes must not leak into enabled mode
  a_enable_clears_word: assert property ($rose(correction_unit_enable) |=>
    gain_multiplier_coeff == 8'h00 && correction_control_1 == 8'h00) else $error("word not cleared");
  a_coeff_by_write: assert property (correction_unit_enable && $past(correction_unit_enable, 2) &&
    $changed(gain_multiplier_coeff) |-> $past(access_phase && pwrite)) else $error("coeff changed alone");
  a_enable_by_write: assert property ($changed(correction_unit_enable) |->
    $past(access_phase && pwrite && paddr == 32'h10400)) else $error("enable changed alone");
endmodule // ppl_loop_regs_monitor
bind ppl_loop_regs ppl_loop_regs_monitor #(.ADDR_W(ADDR_W)) ppl_loop_regs_monitor_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .correction_unit_enable,
  .correction_control_1, .gain_multiplier_coeff);

// file: testbench/ppl_apb_master.sv
`timescale 1ns/10ps
module ppl_apb_master (
  input wire logic pclk,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [31:0] paddr = 32'h0,
  output logic [31:0] pwdata = 32'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] rd,
    output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Released bus shows garbage, not the last request
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask
endmodule // ppl_apb_master

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err, correction_unit_enable;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic signed [15:0] bus_voltage = 16'sh0;
  logic signed [15:0] input_current = 16'sh0;
  logic signed [15:0] volt_loop_out, current_loop_out;
  logic [7:0] correction_control_1, gain_multiplier_coeff;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 32'h135c9962;
  int i;
  int m[int];
  always #2 pclk = ~pclk;
  // Short loop periods keep the run brief
  ppl_loop_regs #(.INNER_DIV(4), .OUTER_DIV(3)) ppl_loop_regs_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_voltage, .input_current,
    .correction_unit_enable, .correction_control_1, .gain_multiplier_coeff, .volt_loop_out, .current_loop_out);
  ppl_apb_master ppl_apb_master_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Model follows every write; enable rise wipes the shared word
  task automatic wr(input int idx, input int d);
    ppl_apb_master_inst.xfer(1'b1, idx * 4, d[7:0], rd, err);
    if (idx == 16'h4100 && d[0] && !m[idx][0]) begin
      m[16'h40f2] = 0;
      m[16'h40f3] = 0;
    end
    m[idx] = d & 8'hff;
    if (idx inside {16'h40ec, 16'h40ee, 16'h40f8, 16'h40fa}) m[idx] = d & 8'h7f;
  endtask
  task automatic rdchk(input int idx);
    ppl_apb_master_inst.xfer(1'b0, idx * 4, 8'h00, rd, err);
    chk(rd, m[idx]);
  endtask
  // Current loop from a known start; out must settle on a clamp
  task automatic loop_run(input int ctl, input int ref16, input int exp);
    wr(16'h4100, ctl & 1);
    wr(16'h40f4, ref16 >> 8);
    wr(16'h40f5, ref16);
    wr(16'h40f6, 0);
    wr(16'h40f7, 0);
    bus_voltage <= $random(seed);
    wr(16'h4100, ctl);
    repeat (60) @(posedge pclk);
    wr(16'h4100, ctl & 1);
    m[16'h40f6] = (exp >> 8) & 8'hff;
    m[16'h40f7] = exp & 8'hff;
    rdchk(16'h40f6);
    rdchk(16'h40f7);
    chk({16'h0, current_loop_out}, exp & 16'hffff);
    $display("loop test ctl %0d done", ctl);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    for (i = 16'h40e8; i <= 16'h4100; i++) m[i] = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 16'h40e8; i < 16'h4100; i++) rdchk(i);
    for (i = 16'h40e8; i < 16'h4100; i++) wr(i, $random(seed));
    for (i = 16'h40e8; i < 16'h4100; i++) rdchk(i);
    chk(gain_multiplier_coeff, 0);
    chk({16'h0, volt_loop_out}, (m[16'h40ea] << 8) | m[16'h40eb]);
    $display("register test done");
    ppl_apb_master_inst.xfer(1'b1, 32'h10800, 8'h5a, rd, err);
    chk(err, 1);
    ppl_apb_master_inst.xfer(1'b0, 32'h103d1, 8'h00, rd, err);
    chk({rd[30:0], err}, 1);
    $display("refusal test done");
    wr(16'h40f2, 8'h5a);
    wr(16'h4100, 1);
    chk(correction_unit_enable, 1);
    rdchk(16'h40f2);
    rdchk(16'h40f3);
    wr(16'h40f2, 8'ha5);
    wr(16'h40f3, 8'h77);
    chk(correction_control_1, 8'ha5);
    chk(gain_multiplier_coeff, 8'h77);
    $display("shared word test done");
    // Kp 0, Ki one half, limits 512 and -256
    for (i = 0; i < 8; i++) wr(16'h40f8 + i, {8'h00, 8'h00, 8'h40, 8'h00, 8'h02, 8'h00, 8'hff, 8'h00} >> (56 - 8 * i));
    loop_run(2, 16'h0100, 16'h0200);
    loop_run(2, 16'hff00, 16'hff00);
    input_current <= $random(seed) & 16'h00ff;
    loop_run(3, 16'h0200, 16'h0200);
    input_current <= 16'sh0040;
    loop_run(3, 16'h0000, 16'h0000);
    print_verdict();
  end
endmodule // tb
